// file: inc/timer_defs.vh
// Purpose: shared constants of the two-instance 16-bit timer block
// Assumes: byte registers, each in the low byte of one APB word
// Notes: definitions only
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// offsets inside one timer window of 0x40 bytes
`define OFS_CTRL_A 6'h00
`define OFS_CTRL_B 6'h04
`define OFS_CTRL_C 6'h08
`define OFS_CNT_LO 6'h0c
`define OFS_CNT_HI 6'h10
`define OFS_CMPA_LO 6'h14
`define OFS_CMPA_HI 6'h18
`define OFS_CMPB_LO 6'h1c
`define OFS_CMPB_HI 6'h20
`define OFS_CMPC_LO 6'h24
`define OFS_CMPC_HI 6'h28
`define OFS_CAP_LO 6'h2c
`define OFS_CAP_HI 6'h30

// timer window selectors (address bits 7:6)
`define WIN_TIMER0 2'h0
`define WIN_TIMER1 2'h1

// shared registers
`define OFS_FLAG0 8'h80
`define OFS_FLAG1 8'h84
`define OFS_MASK0 8'h88
`define OFS_MASK1 8'h8c
`define OFS_CONFIG 8'h90

// field positions
`define CS_MSB 2
`define WGM_HI_MSB 4
`define WGM_HI_LSB 3
`define WGM_LO_MSB 1
`define ACIC_BIT 5
`define ICES_BIT 6
`define ICNC_BIT 7
`define LEGACY_BIT 0
`define F_OVF 0
`define F_CMP_A 1
`define F_CMP_C 3
`define F_CAPT 4

// reset values
`define CTRL_RST 8'h00
`define TEMP_RST 8'h00
`define FLAG_RST 5'h00

// clock source select codes
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

// prescaler tap masks
`define PRE_MASK_8 10'h007
`define PRE_MASK_64 10'h03f
`define PRE_MASK_256 10'h0ff
`define PRE_MASK_1024 10'h3ff

// counter landmarks and fixed tops
`define COUNT_MIN 16'h0000
`define COUNT_MAX 16'hffff
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff

// waveform modes: normal with the fixed all-ones top, the others with a register top
`define MODE_NORMAL 4'h0
`define MODE_CTC_A 4'h4
`define MODE_CTC_CAP 4'hc
`define MODE_PWM_CAP 4'he
`define MODE_PWM_A 4'hf

// noise filter agreement patterns
`define FILT_ALL 4'hf
`define FILT_NONE 4'h0

`endif

// file: rtl/pin_sync.v
// Purpose: two-flop synchroniser, optional filter, edge detector
// Assumes: pin is asynchronous to clk
// Notes: edge pulse is one cycle wide
`default_nettype none
`include "timer_defs.vh"

module pin_sync (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // pin and options
    input wire pin_i,
    input wire filt_en_i,
    input wire rise_i,
    // detected edge
    output reg edge_o
);

    reg meta_reg;  // first stage, read only by sync_reg
    reg sync_reg;  // second stage
    reg [3:0] hist_reg;  // last four synced samples
    reg lvl_reg;  // filtered level
    reg prev_reg;  // level one cycle ago

    // synchronise, filter and detect
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            hist_reg <= `FILT_NONE;
            lvl_reg <= 1'b0;
            prev_reg <= 1'b0;
            edge_o <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            hist_reg <= {hist_reg[2:0], sync_reg};
            // with the filter on, level moves only once four samples agree; off, it follows sync_reg
            if (!filt_en_i) begin
                lvl_reg <= sync_reg;
            end else if (hist_reg == `FILT_ALL) begin
                lvl_reg <= 1'b1;
            end else if (hist_reg == `FILT_NONE) begin
                lvl_reg <= 1'b0;
            end
            prev_reg <= lvl_reg;
            edge_o <= rise_i ? (lvl_reg & ~prev_reg)
                             : (~lvl_reg & prev_reg);
        end
    end

endmodule
`default_nettype wire

// file: rtl/timer_pair.v
// Purpose: two 16-bit timers behind an APB slave, byte registers
// Assumes: an 8-bit view in the low byte of each 32-bit APB word
// Notes: one wait state on every transfer
// Behaviour
// - 16-bit values move as two bytes
// - one high-byte holding register per timer
// - low write commits holding plus low
// - low read snapshots high into holding
// - compare reads bypass the holding register
// - zero count is the sequence minimum
// - all ones is the absolute maximum
// - top is fixed value, A or capture
// - A as PWM top is double buffered
// - no clock source means no counting
// - tick from prescaler or external pin edge
// - compare match sets channel flag
// - capture edge stores count, optional filter
// - control registers are plain byte access
// - every source flagged and individually masked
// - five sources per timer, ten total
// - legacy mode: timer 0 only, A and B
// - counter write beats clear and count
// - stopped counter stays accessible
// - counter high location is the holding register
`default_nettype none
`include "timer_defs.vh"

module timer_pair (
    // clock and reset
    input wire SYS_CLK_I,
    input wire RESET_I,
    // apb slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire PREADY_O,
    output wire [31:0] PRDATA_O,
    output wire PSLVERR_O,
    // pins
    input wire [1:0] EXT_COUNT_I,
    input wire [1:0] CAPTURE_I,
    input wire COMPARATOR_I,
    // masked flags, timer 0 in bits 4:0
    output wire [9:0] IRQ_O
);

    reg pready_reg;  // access phase answer
    reg [7:0] prdata_reg;  // read byte
    reg pslverr_reg;  // unmapped address answer
    reg legacy_reg;  // legacy compatibility mode
    reg [9:0] pre_reg;  // free running prescaler

    wire [1:0] hit_bus;  // address hit per timer
    wire [15:0] rd_bus;  // read byte per timer
    wire [9:0] irq_bus;  // masked flags per timer

    // first access cycle: data is looked up, side effects of reads
    wire acc_first = PSEL_I & PENABLE_I & ~pready_reg;
    // completion edge: writes take effect
    wire acc_done = PSEL_I & PENABLE_I & pready_reg;
    wire rd_first = acc_first & ~PWRITE_I;
    wire wr_done = acc_done & PWRITE_I;
    wire cfg_hit = (PADDR_I == `OFS_CONFIG);

    assign PREADY_O = pready_reg;
    assign PRDATA_O = {24'h000000, prdata_reg};
    assign PSLVERR_O = pslverr_reg;

    // prescaler runs regardless of clock selection
    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            pre_reg <= 10'h000;
        end else begin
            pre_reg <= pre_reg + 10'h001;
        end
    end

    // apb handshake, read data and config register
    always @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            pready_reg <= 1'b0;
            prdata_reg <= 8'h00;
            pslverr_reg <= 1'b0;
            legacy_reg <= 1'b0;
        end else begin
            if (acc_first) begin
                // answer one cycle into the access phase
                pready_reg <= 1'b1;
                pslverr_reg <= ~(|hit_bus | cfg_hit);
                if (PWRITE_I) begin
                    prdata_reg <= 8'h00;
                end else if (cfg_hit) begin
                    prdata_reg <= {7'h00, legacy_reg};
                end else begin
                    prdata_reg <= rd_bus[7:0] | rd_bus[15:8];
                end
            end else begin
                pready_reg <= 1'b0;
                pslverr_reg <= 1'b0;
            end
            if (wr_done & cfg_hit) begin
                legacy_reg <= PWDATA_I[`LEGACY_BIT];
            end
        end
    end

    assign IRQ_O = irq_bus;

    genvar t;
    generate
        for (t = 0; t < 2; t = t + 1) begin : tmr
            localparam [1:0] WIN = (t == 0) ? `WIN_TIMER0 : `WIN_TIMER1;
            localparam [7:0] FLAG_ADR = (t == 0) ? `OFS_FLAG0
                                                 : `OFS_FLAG1;
            localparam [7:0] MASK_ADR = (t == 0) ? `OFS_MASK0
                                                 : `OFS_MASK1;
            localparam IS0 = (t == 0);

            reg [7:0] ctrl_a_reg, ctrl_b_reg, ctrl_c_reg;  // controls
            reg [7:0] temp_reg;  // high-byte holding register
            reg [4:0] flag_reg;  // sticky event flags
            reg [4:0] mask_reg;  // per flag enables
            reg [4:0] irq_reg;  // masked flags
            reg [7:0] rd_byte;  // read mux result
            reg hit;  // this timer owns the address
            reg tick;  // timer tick

            wire [15:0] count, buf_a, buf_b, buf_c, cap;
            wire ovf, capt, ext_edge, capt_edge;
            wire [2:0] match;
            wire [4:0] set;
            wire [4:0] clr;
            wire [2:0] cs = ctrl_b_reg[`CS_MSB:0];
            wire [3:0] mode = {ctrl_b_reg[`WGM_HI_MSB:`WGM_HI_LSB],
                               ctrl_a_reg[`WGM_LO_MSB:0]};
            // timer 1 absent in legacy mode
            wire present = IS0 | ~legacy_reg;
            wire [5:0] ofs = PADDR_I[5:0];
            wire in_win = present & (PADDR_I[7:6] == WIN);
            // compare C hidden in legacy mode
            wire c_gone = legacy_reg & ((ofs == `OFS_CMPC_LO)
                                      | (ofs == `OFS_CMPC_HI));
            wire wr_t = wr_done & in_win;
            wire [15:0] wdata = {temp_reg, PWDATA_I[7:0]};
            wire capt_pin = (IS0 & ctrl_b_reg[`ACIC_BIT]) ? COMPARATOR_I
                                                          : CAPTURE_I[t];

            always @* begin
                case (cs)
                    `CS_STOP: tick = 1'b0;
                    `CS_DIV1: tick = 1'b1;
                    `CS_DIV8: tick = (pre_reg & `PRE_MASK_8)
                                     == `PRE_MASK_8;
                    `CS_DIV64: tick = (pre_reg & `PRE_MASK_64)
                                      == `PRE_MASK_64;
                    `CS_DIV256: tick = (pre_reg & `PRE_MASK_256)
                                       == `PRE_MASK_256;
                    `CS_DIV1024: tick = (pre_reg & `PRE_MASK_1024)
                                        == `PRE_MASK_1024;
                    `CS_EXT_FALL: tick = ext_edge;
                    `CS_EXT_RISE: tick = ext_edge;
                    default: tick = 1'b0;
                endcase
                tick = tick & present;
            end

            // register read mux
            always @* begin
                hit = 1'b0;
                rd_byte = 8'h00;
                if (in_win & ~c_gone) begin
                    hit = 1'b1;
                    case (ofs)
                        `OFS_CTRL_A: rd_byte = ctrl_a_reg;
                        `OFS_CTRL_B: rd_byte = ctrl_b_reg;
                        `OFS_CTRL_C: rd_byte = ctrl_c_reg;
                        `OFS_CNT_LO: rd_byte = count[7:0];
                        `OFS_CNT_HI: rd_byte = temp_reg;
                        `OFS_CMPA_LO: rd_byte = buf_a[7:0];
                        `OFS_CMPA_HI: rd_byte = buf_a[15:8];
                        `OFS_CMPB_LO: rd_byte = buf_b[7:0];
                        `OFS_CMPB_HI: rd_byte = buf_b[15:8];
                        `OFS_CMPC_LO: rd_byte = buf_c[7:0];
                        `OFS_CMPC_HI: rd_byte = buf_c[15:8];
                        `OFS_CAP_LO: rd_byte = cap[7:0];
                        `OFS_CAP_HI: rd_byte = temp_reg;
                        default: hit = 1'b0;
                    endcase
                end else if (present & (PADDR_I == FLAG_ADR)) begin
                    hit = 1'b1;
                    rd_byte = {3'h0, flag_reg};
                end else if (present & (PADDR_I == MASK_ADR)) begin
                    hit = 1'b1;
                    rd_byte = {3'h0, mask_reg};
                end
            end

            assign hit_bus[t] = hit;
            assign rd_bus[t*8 +: 8] = rd_byte;
            assign irq_bus[t*5 +: 5] = irq_reg;

            assign set = {capt, match[2] & ~legacy_reg, match[1:0], ovf}
                       & {5{present}};
            assign clr = (wr_done & (PADDR_I == FLAG_ADR))
                       ? PWDATA_I[4:0] : 5'h00;

            // control, holding, flag and mask registers
            always @(posedge SYS_CLK_I) begin
                if (RESET_I) begin
                    ctrl_a_reg <= `CTRL_RST;
                    ctrl_b_reg <= `CTRL_RST;
                    ctrl_c_reg <= `CTRL_RST;
                    temp_reg <= `TEMP_RST;
                    flag_reg <= `FLAG_RST;
                    mask_reg <= `FLAG_RST;
                    irq_reg <= `FLAG_RST;
                end else begin
                    if (wr_t & (ofs == `OFS_CTRL_A)) begin
                        ctrl_a_reg <= PWDATA_I[7:0];
                    end
                    if (wr_t & (ofs == `OFS_CTRL_B)) begin
                        ctrl_b_reg <= PWDATA_I[7:0];
                    end
                    if (wr_t & (ofs == `OFS_CTRL_C)) begin
                        ctrl_c_reg <= PWDATA_I[7:0];
                    end
                    if (wr_t & ~c_gone & ((ofs == `OFS_CNT_HI)
                        | (ofs == `OFS_CMPA_HI) | (ofs == `OFS_CMPB_HI)
                        | (ofs == `OFS_CMPC_HI) | (ofs == `OFS_CAP_HI)))
                    begin
                        temp_reg <= PWDATA_I[7:0];
                    end else if (rd_first & in_win) begin
                        if (ofs == `OFS_CNT_LO) temp_reg <= count[15:8];
                        if (ofs == `OFS_CAP_LO) temp_reg <= cap[15:8];
                    end
                    if (wr_done & present & (PADDR_I == MASK_ADR)) begin
                        mask_reg <= PWDATA_I[4:0];
                    end
                    // sticky flags, set wins over clear
                    flag_reg <= (flag_reg & ~clr) | set;
                    irq_reg <= flag_reg & mask_reg;
                end
            end

            // full words committed by low-byte writes
            timer_unit core (
                .clk_i(SYS_CLK_I),
                .rst_i(RESET_I),
                .tick_i(tick),
                .mode_i(mode),
                .capt_i(capt_edge),
                .wr_cnt_i(wr_t & (ofs == `OFS_CNT_LO)),
                .wr_a_i(wr_t & (ofs == `OFS_CMPA_LO)),
                .wr_b_i(wr_t & (ofs == `OFS_CMPB_LO)),
                .wr_c_i(wr_t & ~c_gone & (ofs == `OFS_CMPC_LO)),
                .wr_cap_i(wr_t & (ofs == `OFS_CAP_LO)),
                .wdata_i(wdata),
                .count_o(count),
                .buf_a_o(buf_a),
                .buf_b_o(buf_b),
                .buf_c_o(buf_c),
                .cap_o(cap),
                .ovf_o(ovf),
                .match_o(match),
                .capt_o(capt)
            );

            // external count pin, edge chosen by clock select
            pin_sync ext_sync (
                .clk_i(SYS_CLK_I),
                .rst_i(RESET_I),
                .pin_i(EXT_COUNT_I[t]),
                .filt_en_i(1'b0),
                .rise_i(cs == `CS_EXT_RISE),
                .edge_o(ext_edge)
            );

            // capture input with optional noise filter
            pin_sync cap_sync (
                .clk_i(SYS_CLK_I),
                .rst_i(RESET_I),
                .pin_i(capt_pin),
                .filt_en_i(ctrl_b_reg[`ICNC_BIT]),
                .rise_i(ctrl_b_reg[`ICES_BIT]),
                .edge_o(capt_edge)
            );
        end
    endgenerate

endmodule
`default_nettype wire

// file: rtl/timer_unit.v
// Purpose: one 16-bit counter with three compares and a capture
// Assumes: tick is a one-cycle pulse on clk_i
// Notes: event outputs are one-cycle pulses
`default_nettype none
`include "timer_defs.vh"

module timer_unit (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // control
    input wire tick_i,
    input wire [3:0] mode_i,
    input wire capt_i,
    // software writes of full 16-bit values
    input wire wr_cnt_i,
    input wire wr_a_i,
    input wire wr_b_i,
    input wire wr_c_i,
    input wire wr_cap_i,
    input wire [15:0] wdata_i,
    // software view
    output reg [15:0] count_o,
    output reg [15:0] buf_a_o,
    output reg [15:0] buf_b_o,
    output reg [15:0] buf_c_o,
    output reg [15:0] cap_o,
    // events
    output reg ovf_o,
    output reg [2:0] match_o,
    output reg capt_o
);

    reg [15:0] act_a_reg, act_b_reg, act_c_reg;  // active compares
    reg [15:0] top;  // current sequence top
    wire pwm = (mode_i != `MODE_NORMAL) & (mode_i != `MODE_CTC_A)
             & (mode_i != `MODE_CTC_CAP);
    wire cap_is_top = (mode_i == `MODE_CTC_CAP)
                    | (mode_i == `MODE_PWM_CAP);
    wire at_sequence_minimum = (count_o == `COUNT_MIN);
    wire at_max = (count_o == `COUNT_MAX);
    wire at_top = (count_o == top);

    always @* begin
        top = `COUNT_MAX;
        if (mode_i == `MODE_CTC_A || mode_i == `MODE_PWM_A) begin
            top = act_a_reg;
        end else if (cap_is_top) begin
            top = cap_o;
        end else if (!mode_i[3]) begin
            case (mode_i[1:0])
                2'h1: top = `TOP_8BIT;
                2'h2: top = `TOP_9BIT;
                2'h3: top = `TOP_10BIT;
                default: top = `COUNT_MAX;
            endcase
        end
    end

    // counter, buffers, capture and events
    always @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= `COUNT_MIN;
            buf_a_o <= `COUNT_MIN;
            buf_b_o <= `COUNT_MIN;
            buf_c_o <= `COUNT_MIN;
            act_a_reg <= `COUNT_MIN;
            act_b_reg <= `COUNT_MIN;
            act_c_reg <= `COUNT_MIN;
            cap_o <= `COUNT_MIN;
            ovf_o <= 1'b0;
            match_o <= 3'h0;
            capt_o <= 1'b0;
        end else begin
            if (wr_cnt_i) begin
                count_o <= wdata_i;
            end else if (tick_i) begin
                count_o <= at_top ? `COUNT_MIN : count_o + 16'h0001;
            end
            if (wr_a_i) buf_a_o <= wdata_i;
            if (wr_b_i) buf_b_o <= wdata_i;
            if (wr_c_i) buf_c_o <= wdata_i;
            if (!pwm || at_sequence_minimum) begin
                act_a_reg <= buf_a_o;
                act_b_reg <= buf_b_o;
                act_c_reg <= buf_c_o;
            end
            if (cap_is_top) begin
                if (wr_cap_i) cap_o <= wdata_i;
                capt_o <= 1'b0;
            end else begin
                if (capt_i) cap_o <= count_o;
                capt_o <= capt_i;
            end
            ovf_o <= tick_i & ~wr_cnt_i & (pwm ? at_top : at_max);
            match_o[0] <= tick_i & ~wr_cnt_i & (count_o == act_a_reg);
            match_o[1] <= tick_i & ~wr_cnt_i & (count_o == act_b_reg);
            match_o[2] <= tick_i & ~wr_cnt_i & (count_o == act_c_reg);
        end
    end

endmodule
`default_nettype wire

// file: verification/cpu_model.sv
// Purpose: byte-wide processor core model on the bus
// Assumes: every task is entered right after a rising edge
// Notes: 16-bit helpers keep the high/low byte order
`default_nettype none
module cpu_model (
    // clock
    input wire logic clk_i,
    // bus master
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic pready_i,
    input wire logic [31:0] prdata_i,
    input wire logic pslverr_i
);
    logic [7:0] q;
    logic e;
    // idle bus after time zero
    initial begin
        {psel_o, penable_o, pwrite_o} = 3'h0;
        {paddr_o, pwdata_o} = 40'h0;
    end
    // one byte transfer, held until ready
    task automatic xfer(input logic [7:0] a, input logic w,
        input logic [7:0] d, output logic [7:0] rd, output logic er);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= {24'h0, d};
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        rd = prdata_i[7:0];
        er = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // released lines must not keep the last value
        paddr_o <= ~a;
        pwdata_o <= ~pwdata_o;
        @(posedge clk_i);
    endtask
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        xfer(lo + 8'h04, 1'b1, v[15:8], q, e);
        xfer(lo, 1'b1, v[7:0], q, e);
    endtask
    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        xfer(lo, 1'b0, 8'h0, v[7:0], e);
        xfer(lo + 8'h04, 1'b0, 8'h0, v[15:8], e);
    endtask
    // one shared high byte for two registers
    task automatic wr_pair(input logic [7:0] l1, l2, hi, d1, d2);
        xfer(l1 + 8'h04, 1'b1, hi, q, e);
        xfer(l1, 1'b1, d1, q, e);
        xfer(l2, 1'b1, d2, q, e);
    endtask
endmodule
`default_nettype wire

// file: verification/timer_pair_monitor.sv
// Purpose: port checks of the timer pair
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every timer_pair instance below
`default_nettype none
module timer_pair_monitor (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    // bus
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic PREADY_O,
    input wire logic [31:0] PRDATA_O,
    input wire logic PSLVERR_O,
    // masked flags
    input wire logic [9:0] IRQ_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RESET_I);
    // access phase still waiting for its answer
    sequence s_wait;
        PSEL_I && PENABLE_I && !PREADY_O;
    endsequence
    // answer cycle inside a live access
    sequence s_ans;
        PREADY_O && PSEL_I && PENABLE_I;
    endsequence
    a_one_wait: assert property (s_wait |=> s_ans)
        else $error("ready missing after one wait");
    a_ready_pulse: assert property (s_ans |=> !PREADY_O)
        else $error("ready held too long");
    a_err_ready: assert property (PSLVERR_O |-> s_ans)
        else $error("error without answer");
    a_upper_zero: assert property (s_ans |-> PRDATA_O[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_misalign_err: assert property (
        PREADY_O && PADDR_I[1:0] != 2'h0 |-> PSLVERR_O)
        else $error("misaligned access accepted");
    a_ctrl_ok: assert property (
        PREADY_O && PADDR_I[7:4] == 4'h0 && PADDR_I[1:0] == 2'h0
        |-> !PSLVERR_O)
        else $error("control access refused");
    a_ab_ok: assert property (
        PREADY_O && PADDR_I inside {8'h14, 8'h18, 8'h1c, 8'h20}
        |-> !PSLVERR_O)
        else $error("compare a or b refused");
    a_reset_quiet: assert property (
        $fell(RESET_I) |-> !PREADY_O && IRQ_O == 10'h0)
        else $error("outputs busy after reset");
endmodule
bind timer_pair timer_pair_monitor mon_u (
    .SYS_CLK_I(SYS_CLK_I),
    .RESET_I(RESET_I),
    .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I),
    .PADDR_I(PADDR_I),
    .PREADY_O(PREADY_O),
    .PRDATA_O(PRDATA_O),
    .PSLVERR_O(PSLVERR_O),
    .IRQ_O(IRQ_O)
);
`default_nettype wire

// file: verification/timer_pair_tb.sv
// Purpose: self-checking bench of the timer pair
// Assumes: cpu_u makes every bus transfer
// Notes: seeded random data with fixed corner values
`default_nettype none
`define CHK(n, x, y) begin num_checks++; \
    if ((y) !== (x)) begin n_mismatch++; \
    $display("Error %s exp %h got %h", n, x, y); end end
module timer_pair_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata;
    logic [9:0] irq;
    logic [1:0] ext_cnt = 2'h0;
    logic [1:0] cap = 2'h0;
    logic acmp = 1'b0;
    logic [15:0] v, r;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    always #20 sys_clk = ~sys_clk;
    timer_pair dut_u (.SYS_CLK_I(sys_clk), .RESET_I(reset),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
        .PRDATA_O(prdata), .PSLVERR_O(pslverr), .EXT_COUNT_I(ext_cnt),
        .CAPTURE_I(cap), .COMPARATOR_I(acmp), .IRQ_O(irq));
    cpu_model cpu_u (.clk_i(sys_clk), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
        .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr));
    // expected count after n ticks with wrap at top
    function automatic logic [15:0] ticks(input logic [15:0] s,
        input int n, input logic [15:0] top);
        for (int i = 0; i < n; i++)
            s = (s == top) ? 16'h0 : s + 16'h1;
        return s;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu_u.xfer(a, 1'b1, d, b, e);
    endtask
    task automatic rd(input logic [7:0] a);
        cpu_u.xfer(a, 1'b0, 8'h0, b, e);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'h95f6));
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(8'h10);
        `CHK("hold reset", 8'h00, b)
        for (int i = 0; i < 3; i++) begin
            rd(8'(i * 4));
            `CHK("ctrl reset", 8'h00, b)
        end
        v = 16'($urandom);
        wr(8'h08, v[7:0]);
        rd(8'h08);
        `CHK("ctrl c", v[7:0], b)
        // compares read high first: no holding involved
        for (int i = 0; i < 6; i++) begin
            v = (i < 3) ? 16'($urandom) : 16'hffff;
            cpu_u.wr16(8'h14 + 8'(i % 3 * 8), v);
            rd(8'h18 + 8'(i % 3 * 8));
            `CHK("cmp hi", v[15:8], b)
            rd(8'h14 + 8'(i % 3 * 8));
            `CHK("cmp lo", v[7:0], b)
        end
        v = 16'($urandom);
        cpu_u.wr16(8'h0c, v);
        rd(8'h0c);
        `CHK("count lo", v[7:0], b)
        rd(8'h14);
        rd(8'h18);
        rd(8'h10);
        `CHK("snapshot", v[15:8], b)
        cpu_u.wr_pair(8'h14, 8'h1c, 8'h5a, 8'h01, 8'h02);
        rd(8'h20);
        `CHK("shared hi", 8'h5a, b)
        rd(8'h10);
        `CHK("hold view", 8'h5a, b)
        // top from compare a, match a unmasked
        cpu_u.wr16(8'h14, 16'h0020);
        cpu_u.wr16(8'h0c, 16'h0000);
        wr(8'h88, 8'h02);
        wr(8'h04, 8'h09);
        for (int i = 0; i < 10; i++) begin
            cpu_u.rd16(8'h0c, r);
            `CHK("ctc top", 1'b1, r <= 16'h0020)
        end
        `CHK("irq match", 2'h2, irq[1:0])
        wr(8'h04, 8'h08);
        wr(8'h80, 8'h1f);
        rd(8'h80);
        `CHK("flag clear", 8'h00, b)
        rd(8'h0c);
        r[7:0] = b;
        rd(8'h0c);
        `CHK("stopped", r[7:0], b)
        // overflow at all ones in normal mode
        wr(8'h04, 8'h00);
        wr(8'h88, 8'h01);
        cpu_u.wr16(8'h0c, 16'hfffa);
        wr(8'h04, 8'h01);
        repeat (12) @(posedge sys_clk);
        `CHK("irq ovf", 1'b1, irq[0])
        `CHK("irq t1", 5'h00, irq[9:5])
        cpu_u.wr16(8'h0c, 16'h1234);
        cpu_u.rd16(8'h0c, r);
        `CHK("write wins", 1'b1, r - 16'h1234 < 16'h8)
        wr(8'h04, 8'h00);
        wr(8'h88, 8'h00);
        rd(8'h80);
        `CHK("masked", 11'h001, {irq, b[0]})
        wr(8'h80, 8'h1f);
        // external pin, both edge codes
        for (int k = 6; k < 8; k++) begin
            wr(8'h04, 8'(k));
            cpu_u.wr16(8'h0c, 16'hfffe);
            repeat (8) begin
                repeat (4) @(posedge sys_clk);
                ext_cnt <= ~ext_cnt;
            end
            repeat (8) @(posedge sys_clk);
            cpu_u.rd16(8'h0c, r);
            `CHK("ext count", ticks(16'hfffe, 4, 16'hffff), r)
        end
        cpu_u.rd16(8'h4c, r);
        `CHK("t1 idle", 16'h0000, r)
        // capture on rising pin edge
        wr(8'h04, 8'h40);
        v = 16'($urandom);
        cpu_u.wr16(8'h0c, v);
        wr(8'h88, 8'h10);
        cap <= 2'h1;
        repeat (10) @(posedge sys_clk);
        cpu_u.rd16(8'h2c, r);
        `CHK("capture", v, r)
        `CHK("irq capt", 1'b1, irq[4])
        wr(8'h04, 8'h60);
        cpu_u.wr16(8'h0c, ~v);
        acmp <= 1'b1;
        repeat (10) @(posedge sys_clk);
        cpu_u.rd16(8'h2c, r);
        `CHK("cmp capt", ~v, r)
        // legacy refusals and an accepted compare A, then plain unmapped places
        wr(8'h90, 8'h01);
        for (int i = 0; i < 5; i++) begin
            if (i == 3)
                wr(8'h90, 8'h00);
            cpu_u.xfer(i == 2 ? 8'h14 : i == 4 ? 8'h15 : 8'h28 + 8'(i * 36),
                1'b0, 8'h0, b, e);
            `CHK("refusal", i != 2, e)
        end
        wrap_up();
    end
endmodule
`default_nettype wire
